//--- design/ptp_irq_mib_bank.v
`timescale 1ns/100ps
`include "ptp_irq_mib_defs.vh"
// How it works
// RQ1: twelve unit enable bits at 11:0, reset clear
// RQ2: bit 13 enables delay-request egress timestamp interrupt
// RQ3: bit 12 enables sync egress timestamp interrupt
// RQ4: OR of enables drives host enable bit 12
// RQ5: status write-one-clears; OR drives host status bit12
// RQ6: host keeps tuning bit 13 per copper/fiber
// RQ7: regulator bit 7: zero on, one off
// RQ8: host sets bits 15 and 3 before diagnostics
// RQ9: counter word bit 31 flags overflow
// RQ10: counter word bit 30 flags valid count
// RQ11: bits 29:0 hold count, cleared by read
// RQ12: thirty-four statistics counters per port
// RQ13: port counters at indirect offsets 0x00 to 0x21
// RQ14: host reads counters through indirect low/high words
// RQ15: read returns old value, coincident event kept
module ptp_irq_mib_bank #(
   parameter NUM_CNT = `CNT_NUM,
   parameter AW      = `CNT_AW
) (
   // clock and reset
   input  wire          clk,
   input  wire          reset,
   // parallel host bus
   input  wire [10:0]   host_addr,
   input  wire          host_wr,
   input  wire          host_rd,
   input  wire [15:0]   host_wdata,
   output reg  [15:0]   host_rdata,
   // timestamp events, one-cycle pulses
   input  wire [13:0]   ts_event,
   // host interrupt bit 12 contributions
   output reg           host_irq_enable_bit,
   output reg           host_irq_status_bit,
   // statistics count events
   input  wire          count_event,
   input  wire [AW-1:0] count_index,
   output reg           count_ready,
   // analog and receiver controls
   output reg           rx_copper_adjust,
   output reg           regulator_off,
   output reg           high_pulse_mask,
   output reg           tx_bias_reduce
);

   localparam ST_IDLE = 2'b00;
   localparam ST_EVT  = 2'b01;
   localparam ST_HOST = 2'b10;

   reg  [15:0]          ts_ie_reg, ts_ie_next;
   reg  [13:0]          ts_is_reg, ts_is_next;
   reg  [15:0]          rx_tune_reg, ana1_reg, ana3_reg;
   reg  [31:0]          ind_data_reg;
   reg  [1:0]           state_reg;
   reg                  hreq_reg;
   reg  [AW-1:0]        hidx_reg;
   reg                  evt_reg;
   reg  [AW-1:0]        eidx_reg;
   reg  [NUM_CNT-1:0]   valid_map_reg;
   reg                  rd_en;
   reg  [AW-1:0]        rd_addr;
   reg                  wr_en;
   reg  [AW-1:0]        wr_addr;
   reg  [31:0]          wr_data;
   wire [31:0]          ram_q;
   wire [31:0]          word_now;
   wire                 wr_hit;
   wire                 evt_take;
   wire                 hreq_set;
   reg                  evt_done;
   reg                  hreq_done;

   // host write decode, used for every register
   function hit;
      input [10:0] a;
      input [10:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   // one increment of a counter word: overflow sticks once the count wraps
   function [31:0] bump;
      input [31:0] w;
      begin
         bump = {w[`CNT_OVF_BIT] | (&w[`CNT_VALUE_MSB:0]), 1'b1,
                 w[`CNT_VALUE_MSB:0] + 30'h00000001};  // RQ9 RQ10
      end
   endfunction

   stat_counter_ram #(
      .WIDTH (32),
      .DEPTH (NUM_CNT),
      .AW    (AW)
   ) u_ram (
      .clk     (clk),
      .rd_en   (rd_en),
      .rd_addr (rd_addr),
      .rd_data (ram_q),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data)
   );

   // enables: plain read/write, reserved bits kept as written
   always @* begin
      ts_ie_next = ts_ie_reg;
      if (host_wr && hit(host_addr, `OFS_TS_IRQ_ENABLE))
         ts_ie_next = host_wdata;  // RQ1 RQ2 RQ3
   end

   // status: write-one clears, but a same-cycle event wins
   always @* begin
      ts_is_next = ts_is_reg;
      if (host_wr && hit(host_addr, `OFS_TS_IRQ_STATUS))
         ts_is_next = ts_is_reg & ~host_wdata[`TS_SRC_MSB:0];  // RQ5
      ts_is_next = ts_is_next | ts_event;
   end

   // control registers and the registered interrupt bits
   always @(posedge clk) begin
      if (reset) begin
         ts_ie_reg           <= `RST_TS_IRQ_ENABLE;
         ts_is_reg           <= 14'h0000;
         rx_tune_reg         <= `RST_RX_TUNING;
         ana1_reg            <= `RST_REGULATOR;
         ana3_reg            <= `RST_CABLE_PREP;
         host_irq_enable_bit <= 1'b0;
         host_irq_status_bit <= 1'b0;
      end else begin
         ts_ie_reg           <= ts_ie_next;
         ts_is_reg           <= ts_is_next;
         host_irq_enable_bit <= |ts_ie_next[`TS_SRC_MSB:0];  // RQ4
         host_irq_status_bit <= |ts_is_next;  // RQ5
         if (host_wr && hit(host_addr, `OFS_RX_TUNING))
            rx_tune_reg <= host_wdata;  // RQ6
         if (host_wr && hit(host_addr, `OFS_REGULATOR))
            ana1_reg <= host_wdata;
         if (host_wr && hit(host_addr, `OFS_CABLE_PREP))
            ana3_reg <= host_wdata;  // RQ8
      end
   end

   // analog controls straight from flops, one cycle after the register
   always @(posedge clk) begin
      if (reset) begin
         rx_copper_adjust <= 1'b1;
         regulator_off    <= 1'b0;
         high_pulse_mask  <= 1'b0;
         tx_bias_reduce   <= 1'b0;
      end else begin
         rx_copper_adjust <= rx_tune_reg[`RX_COPPER_BIT];
         regulator_off    <= ana1_reg[`REG_OFF_BIT];  // RQ7
         high_pulse_mask  <= ana3_reg[`HIGH_PULSE_MASK_BIT];
         tx_bias_reduce   <= ana3_reg[`TX_BIAS_REDUCE_BIT];
      end
   end

   // host read mux; unmapped offsets read zero
   always @(posedge clk) begin
      if (reset)
         host_rdata <= 16'h0000;
      else if (host_rd) begin
         case (host_addr)
            `OFS_TS_IRQ_ENABLE: host_rdata <= ts_ie_reg;
            `OFS_TS_IRQ_STATUS: host_rdata <= {2'b00, ts_is_reg};
            `OFS_RX_TUNING:     host_rdata <= rx_tune_reg;
            `OFS_REGULATOR:     host_rdata <= ana1_reg;
            `OFS_CABLE_PREP:    host_rdata <= ana3_reg;
            `OFS_INDIRECT_CTRL: host_rdata <= {3'b000, hreq_reg, 6'h00, hidx_reg};
            `OFS_INDIRECT_LOW:  host_rdata <= ind_data_reg[15:0];  // RQ14
            `OFS_INDIRECT_HIGH: host_rdata <= ind_data_reg[31:16];  // RQ14
            default:            host_rdata <= 16'h0000;
         endcase
      end
   end

   // a word never written since reset reads as zero: no count, not valid
   assign word_now = (hidx_reg < NUM_CNT && valid_map_reg[hidx_reg]) ? ram_q : 32'h00000000;
   assign wr_hit   = evt_reg && (eidx_reg == hidx_reg);
   assign evt_take = count_event && count_ready;
   assign hreq_set = host_wr && hit(host_addr, `OFS_INDIRECT_CTRL) && host_wdata[`IND_READ_BIT];

   // counter engine: events and host reads share the RAM, host first
   always @* begin
      rd_en     = 1'b0;
      rd_addr   = hidx_reg;
      wr_en     = 1'b0;
      wr_addr   = hidx_reg;
      wr_data   = 32'h00000000;
      evt_done  = 1'b0;
      hreq_done = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (hreq_reg) begin
               rd_en = 1'b1;
            end else if (evt_reg) begin
               rd_en   = 1'b1;
               rd_addr = eidx_reg;
            end
         end
         ST_EVT: begin
            wr_addr  = eidx_reg;
            wr_en    = (eidx_reg < NUM_CNT);  // RQ12
            wr_data  = bump(valid_map_reg[eidx_reg] ? ram_q : 32'h00000000);
            evt_done = 1'b1;
         end
         ST_HOST: begin
            hreq_done = 1'b1;
            wr_en     = (hidx_reg < NUM_CNT);  // RQ11
            if (wr_hit) begin
               // event for the same counter folds into the cleared word
               wr_data  = bump(32'h40000000);  // RQ15
               evt_done = 1'b1;
            end else
               wr_data = 32'h40000000;
         end
         default: begin
            rd_en = 1'b0;
         end
      endcase
   end

   // engine state, pending requests and valid map
   always @(posedge clk) begin
      if (reset) begin
         state_reg     <= ST_IDLE;
         hreq_reg      <= 1'b0;
         hidx_reg      <= {AW{1'b0}};
         evt_reg       <= 1'b0;
         eidx_reg      <= {AW{1'b0}};
         count_ready   <= 1'b0;
         valid_map_reg <= {NUM_CNT{1'b0}};
         ind_data_reg  <= 32'h00000000;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (hreq_reg)
                  state_reg <= ST_HOST;
               else if (evt_reg)
                  state_reg <= ST_EVT;
            end
            default: state_reg <= ST_IDLE;
         endcase
         if (hreq_done)
            ind_data_reg <= word_now;  // RQ15 RQ13
         // a new request is taken only while none is pending
         if (hreq_set && !hreq_reg) begin
            hreq_reg <= 1'b1;
            hidx_reg <= host_wdata[`IND_INDEX_MSB:0];  // RQ13
         end else if (hreq_done)
            hreq_reg <= 1'b0;
         // one event slot; back-pressure keeps events from being dropped
         if (evt_take) begin
            evt_reg  <= 1'b1;
            eidx_reg <= count_index;
         end else if (evt_done)
            evt_reg <= 1'b0;
         count_ready <= !(evt_take || (evt_reg && !evt_done));
         if (wr_en)
            valid_map_reg[wr_addr] <= 1'b1;  // RQ10
      end
   end

endmodule // ptp_irq_mib_bank

//--- design/ptp_irq_mib_defs.vh
`ifndef PTP_IRQ_MIB_DEFS_VH
`define PTP_IRQ_MIB_DEFS_VH

// host bus byte offsets of the bank
`define OFS_INDIRECT_CTRL     11'h030
`define OFS_INDIRECT_LOW      11'h02C
`define OFS_INDIRECT_HIGH     11'h02E
`define OFS_TS_IRQ_STATUS     11'h68C
`define OFS_TS_IRQ_ENABLE     11'h68E
`define OFS_RX_TUNING         11'h734
`define OFS_REGULATOR         11'h748
`define OFS_CABLE_PREP        11'h74C

// reset values
`define RST_TS_IRQ_ENABLE     16'h0000
`define RST_RX_TUNING         16'h3020
`define RST_REGULATOR         16'h0000
`define RST_CABLE_PREP        16'h0000

// field positions
`define TS_UNIT_MSB           11
`define TS_SYNC_BIT           12
`define TS_DELAY_BIT          13
`define TS_SRC_MSB            13
`define RX_COPPER_BIT         13
`define REG_OFF_BIT           7
`define HIGH_PULSE_MASK_BIT   15
`define TX_BIAS_REDUCE_BIT    3
`define IND_READ_BIT          12
`define IND_INDEX_MSB         5

// statistics counter word layout
`define CNT_OVF_BIT           31
`define CNT_VALID_BIT         30
`define CNT_VALUE_MSB         29
`define CNT_NUM               34
`define CNT_AW                6

`endif

//--- design/stat_counter_ram.v
`timescale 1ns/100ps
// small synchronous RAM holding the statistics words; read data registered
module stat_counter_ram #(
   parameter WIDTH = 32,
   parameter DEPTH = 34,
   parameter AW    = 6
) (
   // clock
   input  wire             clk,
   // read port
   input  wire             rd_en,
   input  wire [AW-1:0]    rd_addr,
   output reg  [WIDTH-1:0] rd_data,
   // write port
   input  wire             wr_en,
   input  wire [AW-1:0]    wr_addr,
   input  wire [WIDTH-1:0] wr_data
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];

   // no reset on contents; the owner tracks which words were ever written
   always @(posedge clk) begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
      if (rd_en)
         rd_data <= mem[rd_addr];
   end

endmodule // stat_counter_ram

//--- test/ptp_irq_mib_bank_asserts.sv
`timescale 1ns/100ps
`include "ptp_irq_mib_defs.vh"
// port-level checks of the bank
module ptp_irq_mib_bank_asserts (
   // clock, reset and host bus
   input wire        clk,
   input wire        reset,
   input wire [10:0] host_addr,
   input wire        host_wr,
   input wire        host_rd,
   input wire [15:0] host_wdata,
   input wire [15:0] host_rdata,
   // events and flags
   input wire [13:0] ts_event,
   input wire        host_irq_enable_bit,
   input wire        host_irq_status_bit,
   input wire        count_event,
   input wire        count_ready,
   // control outputs
   input wire        rx_copper_adjust,
   input wire        regulator_off,
   input wire        high_pulse_mask,
   input wire        tx_bias_reduce
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   // register writes by target; control outputs lag the register by one edge
   wire ie_wr = host_wr && host_addr == `OFS_TS_IRQ_ENABLE;
   wire tu_wr = host_wr && host_addr == `OFS_RX_TUNING;
   wire rg_wr = host_wr && host_addr == `OFS_REGULATOR;
   wire cp_wr = host_wr && host_addr == `OFS_CABLE_PREP;
   wire st_wr = host_wr && host_addr == `OFS_TS_IRQ_STATUS;
   chk_irq_en_or: assert property (ie_wr |-> ##2 host_irq_enable_bit == |$past(host_wdata[13:0], 2))
      else $error("enable summary wrong");
   chk_copper_follow: assert property (tu_wr |-> ##2 rx_copper_adjust == $past(host_wdata[13], 2))
      else $error("receiver adjust wrong");
   chk_regoff_follow: assert property (rg_wr |-> ##2 regulator_off == $past(host_wdata[7], 2))
      else $error("regulator off wrong");
   chk_cable_follow: assert property (cp_wr |-> ##2 {high_pulse_mask, tx_bias_reduce} ==
      {$past(host_wdata[15], 2), $past(host_wdata[3], 2)})
      else $error("cable prep bits wrong");
   chk_status_set: assert property (|ts_event |=> host_irq_status_bit)
      else $error("status not set");
   chk_status_keep: assert property (host_irq_status_bit && !st_wr |=> host_irq_status_bit)
      else $error("status lost");
   chk_status_quiet: assert property (!host_irq_status_bit && ts_event == 14'h0000 |=> !host_irq_status_bit)
      else $error("status set without event");
   chk_ready_cycle: assert property (count_event && count_ready |=> !count_ready ##[1:20] count_ready)
      else $error("event slot timing wrong");
   chk_rdata_hold: assert property (!host_rd && !$past(host_rd) |=> $stable(host_rdata))
      else $error("read data moved");
   // main scenarios
   cover property (count_event && count_ready);
   cover property (st_wr && host_irq_status_bit);
   cover property (ie_wr && host_wdata[13]);
endmodule // ptp_irq_mib_bank_asserts

bind ptp_irq_mib_bank ptp_irq_mib_bank_asserts chk_u (.clk(clk), .reset(reset), .host_addr(host_addr),
   .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
   .ts_event(ts_event), .host_irq_enable_bit(host_irq_enable_bit), .host_irq_status_bit(host_irq_status_bit),
   .count_event(count_event), .count_ready(count_ready), .rx_copper_adjust(rx_copper_adjust),
   .regulator_off(regulator_off), .high_pulse_mask(high_pulse_mask), .tx_bias_reduce(tx_bias_reduce));

//--- test/host_bus_model.sv
`timescale 1ns/100ps
`include "ptp_irq_mib_defs.vh"
// host processor; bus changes only at the falling edge
module host_bus_model (
   // clock
   input  wire        clk,
   // host bus
   output reg  [10:0] host_addr,
   output reg         host_wr,
   output reg         host_rd,
   output reg  [15:0] host_wdata,
   input  wire [15:0] host_rdata
);
   initial begin
      host_addr = 11'h000;
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_wdata = 16'h0000;
   end
   // one-cycle strobe; data inverted after so stale values never match
   task wr(input [10:0] a, input [15:0] d);
      begin
         @(negedge clk);
         host_addr = a;
         host_wdata = d;
         host_wr = 1'b1;
         @(negedge clk);
         host_wr = 1'b0;
         host_wdata = ~d;
         host_addr = ~a;
      end
   endtask
   // read data is registered: taken half a cycle after the answering edge
   task rd(input [10:0] a, output [15:0] d);
      begin
         @(negedge clk);
         host_addr = a;
         host_rd = 1'b1;
         @(negedge clk);
         d = host_rdata;
         host_rd = 1'b0;
      end
   endtask
   // indirect command, then low and high halves
   task rd_counter(input [5:0] idx, output [31:0] w);
      begin
         wr(`OFS_INDIRECT_CTRL, {4'h1, 6'h00, idx});
         repeat (4) @(negedge clk);
         rd(`OFS_INDIRECT_LOW, w[15:0]);
         rd(`OFS_INDIRECT_HIGH, w[31:16]);
      end
   endtask
endmodule // host_bus_model

//--- test/tb.sv
`timescale 1ns/100ps
`include "ptp_irq_mib_defs.vh"
module tb;
   // stimulus and observed ports
   reg         clk;
   reg         reset;
   reg  [13:0] ts_event;
   reg         count_event;
   reg  [5:0]  count_index;
   wire [10:0] host_addr;
   wire [15:0] host_wdata, host_rdata;
   wire        host_wr, host_rd, irq_en, irq_st, count_ready;
   wire        copper, reg_off, hp_mask, bias_red;
   integer     bad_count = 0, num_checks = 0, cycles = 0, i, k, n;
   integer     seed = 32'ha92a47d6;
   reg  [15:0] d, v, sh [0:3];
   reg  [31:0] w;
   ptp_irq_mib_bank dut_u (.clk(clk), .reset(reset), .host_addr(host_addr), .host_wr(host_wr),
      .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata), .ts_event(ts_event),
      .host_irq_enable_bit(irq_en), .host_irq_status_bit(irq_st), .count_event(count_event),
      .count_index(count_index), .count_ready(count_ready), .rx_copper_adjust(copper),
      .regulator_off(reg_off), .high_pulse_mask(hp_mask), .tx_bias_reduce(bias_red));
   host_bus_model host_u (.clk(clk), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
      .host_wdata(host_wdata), .host_rdata(host_rdata));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // hang guard, far above the few hundred cycles needed
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count = bad_count + 1;
         complete_run;
      end
   end
   function [10:0] ofs(input integer j);
      ofs = j == 0 ? `OFS_TS_IRQ_ENABLE : j == 1 ? `OFS_RX_TUNING : j == 2 ? `OFS_REGULATOR : `OFS_CABLE_PREP;
   endfunction
   // expected control outputs from the shadow copies
   function [4:0] flags();
      flags = {|sh[0][13:0], sh[1][13], sh[2][7], sh[3][15], sh[3][3]};
   endfunction
   function [31:0] word(input integer c);
      word = c == 0 ? 32'h00000000 : {2'b01, 30'h0} + c;
   endfunction
   task check(input string nm, input [31:0] e, input [31:0] g);
      begin
         num_checks = num_checks + 1;
         if (g !== e) begin
            bad_count = bad_count + 1;
            $display("unexpected %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // one count event, sent once the slot is free or after 20 cycles of waiting
   task bump(input [5:0] idx);
      integer t;
      begin
         t = 0;
         @(negedge clk);
         while (count_ready !== 1'b1 && t < 20) begin
            @(negedge clk);
            t = t + 1;
         end
         count_index = idx;
         count_event = 1'b1;
         @(negedge clk);
         count_event = 1'b0;
         count_index = ~idx;
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", num_checks, bad_count);
         if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   initial begin
      reset = 1'b1;
      ts_event = 14'h0000;
      count_event = 1'b0;
      count_index = 6'h00;
      repeat (5) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      check("slot free", 1, count_ready);
      for (i = 0; i < 4; i = i + 1) begin
         sh[i] = i == 1 ? 16'h3020 : 16'h0000;
         host_u.rd(ofs(i), d);
         check("reset value", sh[i], d);
      end
      check("reset outputs", flags(), {irq_en, copper, reg_off, hp_mask, bias_red});
      // corner bits first on the enable register, then random data
      for (n = 0; n < 28; n = n + 1) begin
         k = n % 4;
         v = (n < 12 && k == 0) ? 16'h2000 >> (n / 4) : $random(seed);
         sh[k] = v;
         host_u.wr(ofs(k), v);
         host_u.rd(ofs(k), d);
         check("register", v, d);
         check("outputs", flags(), {irq_en, copper, reg_off, hp_mask, bias_red});
      end
      host_u.wr(11'h700, 16'hFFFF);
      host_u.rd(11'h700, d);
      check("reserved offset", 0, d);
      // second reset in mid-run: written controls must fall back
      reset = 1'b1;
      repeat (5) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      for (i = 0; i < 4; i = i + 1)
         sh[i] = i == 1 ? 16'h3020 : 16'h0000;
      check("outputs after reset", flags(), {irq_en, copper, reg_off, hp_mask, bias_red});
      host_u.wr(`OFS_CABLE_PREP, 16'h8008);
      host_u.wr(`OFS_RX_TUNING, 16'h3020);
      for (i = 0; i < 14; i = i + 1) begin
         @(negedge clk);
         ts_event = 14'h0001 << i;
         @(negedge clk);
         ts_event = 14'h0000;
         host_u.rd(`OFS_TS_IRQ_STATUS, d);
         check("status bits", 16'h0001 << i, d);
         check("status summary", 1, irq_st);
         host_u.wr(`OFS_TS_IRQ_STATUS, 16'h0001 << i);
         check("status cleared", 0, irq_st);
      end
      // an event in the same cycle as its clear must survive
      fork
         host_u.wr(`OFS_TS_IRQ_STATUS, 16'h3FFF);
         begin
            @(negedge clk);
            ts_event = 14'h0004;
            @(negedge clk);
            ts_event = 14'h0000;
         end
      join
      check("event beats clear", 1, irq_st);
      host_u.rd(`OFS_TS_IRQ_STATUS, d);
      check("kept status bit", 16'h0004, d);
      host_u.wr(`OFS_TS_IRQ_STATUS, 16'h0004);
      host_u.rd_counter(6'd5, w);
      check("unused counter", 0, w);
      for (i = 0; i < 6; i = i + 1) begin
         k = i == 0 ? 0 : i == 1 ? 31 : i == 2 ? 33 : {$random(seed)} % 34;
         n = 1 + {$random(seed)} % 5;
         repeat (n) bump(k[5:0]);
         bump(6'd1);
         host_u.rd_counter(k[5:0], w);
         check("counter word", word(k == 1 ? n + 1 : n), w);
         host_u.rd_counter(k[5:0], w);
         check("counter cleared", {2'b01, 30'h0}, w);
         host_u.rd_counter(6'd1, w);
      end
      // count event racing a read of the same counter: old value out, event kept
      host_u.rd_counter(6'd7, w);
      repeat (2) bump(6'd7);
      fork
         host_u.rd_counter(6'd7, w);
         bump(6'd7);
      join
      check("read with event", word(2), w);
      host_u.rd_counter(6'd7, w);
      check("event kept", word(1), w);
      host_u.rd_counter(6'd34, w);
      check("index past end", 0, w);
      complete_run;
   end
endmodule // tb
